// ---- rtl/kmls_pkg.sv ----
package kmls_pkg;
  localparam int ADDR_W = 18;
  // printed offsets are word indices; byte address is four times the index
  localparam logic [15:0] IDX_DATA = 16'hFE80;
  localparam logic [15:0] IDX_STAT = 16'hFE82;
  localparam logic [15:0] IDX_CTRL = 16'hFE84;
  localparam logic [15:0] IDX_DRIVE = 16'hFE86;
  localparam logic [15:0] IDX_SENSE = 16'hFE88;
  localparam logic [15:0] IDX_MASK = 16'hFE8A;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DRIVE_RST = 8'h47;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam int CTRL_EN = 0;
  localparam int CTRL_XMT = 1;
  localparam int CTRL_DEB_LSB = 4;
  localparam int MASK_START = 0;
  localparam int MASK_DONE = 1;
  localparam int ST_START = 0;
  localparam int ST_DONE_B = 1;
  localparam int ST_PARITY_FAULT_FLAG = 2;
  localparam int ST_ACH_LSB = 3;
  localparam int ST_FERR = 6;
  localparam logic [3:0] CNT_PARITY_RX = 4'h8;
  localparam logic [3:0] CNT_LAST = 4'h9;
  localparam logic [3:0] CNT_PARITY_TX = 4'h7;
  localparam logic [3:0] CNT_STOP_TX = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT = 2'b01,
    ST_ACT = 2'b11,
    ST_END = 2'b10
  } kmls_state_t;

  // channel enable bits of the line drive register, channel 3 at the top
  function automatic logic [3:0] kmls_clk_bits(input logic [7:0] r);
    kmls_clk_bits = {r[7], r[5], r[4], r[3]};
  endfunction

  function automatic logic [3:0] kmls_dat_bits(input logic [7:0] r);
    kmls_dat_bits = {r[6], r[2], r[1], r[0]};
  endfunction

  function automatic logic [2:0] kmls_ach_code(input logic [1:0] ch);
    case (ch)
      2'd0: kmls_ach_code = 3'h1;
      2'd1: kmls_ach_code = 3'h2;
      2'd2: kmls_ach_code = 3'h4;
      default: kmls_ach_code = 3'h5;
    endcase
  endfunction
endpackage

// ---- rtl/kmls_shifter.sv ----
`timescale 1ns/10ps
// Functional notes
// - stop bit: end state, clocks low, done flag
// - end state interrupt when done mask or start mask set
// - end states hold until engine reset
// - enabled transmit starts inactive, clocks low
// - one enabled channel: its clock released
// - start bit: clock fall with data low
// - transmit start drives bit 0, sets drives
// - start sets flag, channel code, interrupt
// - next seven falls drive bits 1 to 7
// - ninth fall drives odd parity bit
// - tenth fall drives stop one, releases data
// - data low at eleventh fall ends transmit
// - transmit end: clocks low, done flag, interrupt
// - clearing all channel enables aborts transfer
// - data byte holds received byte; send shifts it out
// - status clears on engine reset, not read
// - status bit layout start done parity channel
// - channel codes, lowest channel wins
// - drive bit zero pulls data line low
// - engine reset: status zero, lines from bits
// - control bit 0 enable, bit 1 direction
module kmls_shifter
  import kmls_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] clk_line_in,
  output logic [3:0] clk_line_out,
  output logic [3:0] clk_line_oe,
  input wire logic [3:0] dat_line_in,
  output logic [3:0] dat_line_out,
  output logic [3:0] dat_line_oe,
  output logic irq
);

  logic [7:0] link_data_byte;
  logic [7:0] link_control;
  logic [7:0] line_drive_control;
  logic [7:0] link_irq_mask;
  logic [7:0] link_transfer_status;
  kmls_state_t state;
  logic [3:0] cnt;
  logic [1:0] act;
  logic tx_bit;
  logic par_bit;
  logic start_flag, done_flag, parity_fault_flag_flag, ferr_flag;
  logic [2:0] active_channel_field;
  logic [3:0] clk_s1, clk_s2, dat_s1, dat_s2;
  logic [3:0] clk_deb, fall;
  logic [2:0] deb_cnt [4];
  logic [ADDR_W-1:0] aw_addr;
  logic aw_full, w_full;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_wr;
  logic eng_rst;
  logic [3:0] en_ch, wdat;
  logic transmit_direction_bit;
  logic [3:0] hit;
  logic start_hit;
  logic [1:0] hit_ch;
  logic [1:0] hit_ch_q;
  logic fall_act, dat_act;
  logic [3:0] next_clk_oe, next_dat_oe;

  assign en_ch = kmls_clk_bits(line_drive_control);
  assign wdat = kmls_dat_bits(line_drive_control);
  assign transmit_direction_bit = link_control[CTRL_XMT];
  assign eng_rst = !link_control[CTRL_EN] || (en_ch == 4'h0);

  // ---------------- register bus ----------------
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_full <= 1'b0;
      end
    end
  end

  function automatic logic [15:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[17:2];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [15:0] i;
    i = a[17:2];
    mapped = (i == IDX_DATA) || (i == IDX_STAT) || (i == IDX_CTRL) ||
             (i == IDX_DRIVE) || (i == IDX_SENSE) || (i == IDX_MASK);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      case (word_idx(s_axi_araddr))
        IDX_DATA: s_axi_rdata <= {24'h000000, link_data_byte};
        IDX_STAT: s_axi_rdata <= {24'h000000, link_transfer_status};
        IDX_CTRL: s_axi_rdata <= {24'h000000, link_control};
        IDX_DRIVE: s_axi_rdata <= {24'h000000, line_drive_control};
        IDX_SENSE: s_axi_rdata <= {24'h000000, dat_s2, clk_deb};
        IDX_MASK: s_axi_rdata <= {24'h000000, link_irq_mask};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic wr_ok;
  assign wr_ok = do_wr && w_lane0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_control <= CTRL_RST;
      link_irq_mask <= MASK_RST;
    end else if (wr_ok) begin
      if (word_idx(aw_addr) == IDX_CTRL) begin
        link_control <= w_byte;
      end
      if (word_idx(aw_addr) == IDX_MASK) begin
        link_irq_mask <= w_byte;
      end
    end
  end

  // hardware setting the data drives on a transmit start wins over a bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_drive_control <= DRIVE_RST;
    end else if (state == ST_WAIT && start_hit && transmit_direction_bit) begin
      line_drive_control <= line_drive_control | 8'h47;
    end else if (wr_ok && word_idx(aw_addr) == IDX_DRIVE) begin
      line_drive_control <= w_byte;
    end
  end

  // ---------------- line sampling ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_s1 <= 4'hF;
      clk_s2 <= 4'hF;
      dat_s1 <= 4'hF;
      dat_s2 <= 4'hF;
    end else begin
      clk_s1 <= clk_line_in;
      clk_s2 <= clk_s1;
      dat_s1 <= dat_line_in;
      dat_s2 <= dat_s1;
    end
  end

  // a new clock level is taken after it stood for debounce setting plus one cycles
  for (genvar i = 0; i < 4; i++) begin : g_deb
    logic take;
    assign take = (clk_s2[i] != clk_deb[i]) &&
                  (deb_cnt[i] == link_control[CTRL_DEB_LSB +: 3]);
    assign fall[i] = take && !clk_s2[i];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        clk_deb[i] <= 1'b1;
        deb_cnt[i] <= 3'h0;
      end else if (clk_s2[i] == clk_deb[i] || take) begin
        deb_cnt[i] <= 3'h0;
        if (take) begin
          clk_deb[i] <= clk_s2[i];
        end
      end else begin
        deb_cnt[i] <= deb_cnt[i] + 3'h1;
      end
    end
  end

  // ---------------- shift engine ----------------
  assign hit = fall & ~dat_s2 & en_ch;
  assign start_hit = |hit;
  assign hit_ch = hit[0] ? 2'd0 : hit[1] ? 2'd1 : hit[2] ? 2'd2 : 2'd3;
  assign fall_act = fall[act];
  assign dat_act = dat_s2[act];

  always_ff @(posedge aclk) begin
    if (!aresetn || eng_rst) begin
      state <= ST_OFF;
    end else begin
      unique case (state)
        ST_OFF: state <= ST_WAIT;
        ST_WAIT: if (start_hit) state <= ST_ACT;
        ST_ACT: begin
          if (fall_act && cnt == CNT_LAST && (!transmit_direction_bit || !dat_act)) begin
            state <= ST_END;
          end
        end
        ST_END: state <= ST_END;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || eng_rst) begin
      start_flag <= 1'b0;
      done_flag <= 1'b0;
      parity_fault_flag_flag <= 1'b0;
      ferr_flag <= 1'b0;
      active_channel_field <= 3'h0;
      act <= 2'd0;
    end else if (state == ST_WAIT && start_hit) begin
      start_flag <= 1'b1;
      active_channel_field <= kmls_ach_code(hit_ch);
      act <= hit_ch;
    end else if (state == ST_ACT && fall_act && cnt == CNT_LAST) begin
      if (!transmit_direction_bit) begin
        done_flag <= 1'b1;
        ferr_flag <= !dat_act;
        parity_fault_flag_flag <= !(^link_data_byte ^ par_bit);
      end else if (!dat_act) begin
        done_flag <= 1'b1;
      end
    end
  end

  assign link_transfer_status = {1'b0, ferr_flag, active_channel_field, parity_fault_flag_flag, done_flag, start_flag};

  // edge count after the start edge; saturates at the last bit
  always_ff @(posedge aclk) begin
    if (!aresetn || state != ST_ACT) begin
      cnt <= 4'h0;
    end else if (fall_act && cnt != CNT_LAST) begin
      cnt <= cnt + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_data_byte <= 8'h00;
      tx_bit <= 1'b1;
      par_bit <= 1'b1;
    end else if (state == ST_WAIT && start_hit && transmit_direction_bit) begin
      tx_bit <= link_data_byte[0];
      par_bit <= ~^link_data_byte;
    end else if (state == ST_ACT && fall_act) begin
      if (!transmit_direction_bit) begin
        if (cnt < CNT_PARITY_RX) begin
          link_data_byte <= {dat_act, link_data_byte[7:1]};
        end else if (cnt == CNT_PARITY_RX) begin
          par_bit <= dat_act;
        end
      end else if (cnt < CNT_PARITY_TX) begin
        tx_bit <= link_data_byte[1];
        link_data_byte <= {1'b0, link_data_byte[7:1]};
      end else if (cnt == CNT_PARITY_TX) begin
        tx_bit <= par_bit;
      end else if (cnt == CNT_STOP_TX) begin
        tx_bit <= 1'b1;
      end
    end else if (wr_ok && word_idx(aw_addr) == IDX_DATA) begin
      link_data_byte <= w_byte;
    end
  end

  // ---------------- line drive (open drain: enable pulls low) ----------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      unique case (state)
        ST_OFF: begin
          next_clk_oe[i] = !en_ch[i] || eng_rst == 1'b0;
          next_dat_oe[i] = !wdat[i];
        end
        ST_WAIT: begin
          next_clk_oe[i] = !en_ch[i];
          next_dat_oe[i] = transmit_direction_bit ? !wdat[i] : (!wdat[i] && !en_ch[i]);
        end
        ST_ACT: begin
          next_clk_oe[i] = (act != 2'(i));
          if (transmit_direction_bit && act == 2'(i)) begin
            next_dat_oe[i] = !tx_bit;
          end else begin
            next_dat_oe[i] = !wdat[i] && (transmit_direction_bit || act != 2'(i));
          end
        end
        ST_END: begin
          next_clk_oe[i] = 1'b1;
          next_dat_oe[i] = !wdat[i];
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_line_oe <= 4'hF;
      dat_line_oe <= 4'h0;
    end else begin
      clk_line_oe <= next_clk_oe;
      dat_line_oe <= next_dat_oe;
    end
  end

  assign clk_line_out = 4'h0;
  assign dat_line_out = 4'h0;

  assign irq = (start_flag && link_irq_mask[MASK_START]) ||
               (done_flag && link_irq_mask[MASK_DONE]);

  // ---------------- checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_end_held;
    state == ST_END && !eng_rst;
  endsequence

  sequence s_rx_stop;
    state == ST_ACT && !transmit_direction_bit && fall_act && cnt == CNT_LAST && !eng_rst;
  endsequence

  end_clocks_a: assert property (s_end_held |-> ##1 clk_line_oe == 4'hF)
    else $error("clocks not held low in end state");
  end_irq_a: assert property (done_flag && link_irq_mask[MASK_DONE] |-> irq)
    else $error("done interrupt missing");
  end_hold_a: assert property (s_end_held ##1 !eng_rst |-> state == ST_END)
    else $error("end state left without reset");
  rx_done_a: assert property (s_rx_stop ##1 !eng_rst |-> done_flag && state == ST_END)
    else $error("stop bit did not complete receive");
  abort_off_a: assert property (state != ST_OFF && en_ch == 4'h0 |=> state == ST_OFF)
    else $error("abort did not reset engine");
  status_clr_a: assert property (eng_rst |=> link_transfer_status == 8'h00)
    else $error("status not cleared");
  start_set_a: assert property (state == ST_WAIT && start_hit && !eng_rst
                               |=> start_flag && active_channel_field == kmls_ach_code(hit_ch_q))
    else $error("start flag or channel wrong");
  tx_bit0_a: assert property (state == ST_WAIT && start_hit && transmit_direction_bit && !eng_rst
                             |=> tx_bit == $past(link_data_byte[0]))
    else $error("bit 0 not driven at start");
  ach_legal_a: assert property (start_flag |-> active_channel_field inside {3'h1, 3'h2, 3'h4, 3'h5})
    else $error("illegal channel code");

  always_ff @(posedge aclk) begin
    hit_ch_q <= hit_ch;
  end

endmodule

// ---- sim/kmls_periph.sv ----
`timescale 1ns/10ps
module kmls_periph (
  input wire logic [3:0] clk_line,
  input wire logic [3:0] dat_line,
  output logic [3:0] clk_pull,
  output logic [3:0] dat_pull
);
  // link clock rests high between frames
  initial begin
    clk_pull = 4'h0;
    dat_pull = 4'h0;
  end

  // peripheral to engine: start, byte lsb first, parity, stop
  task automatic send(input int ch, input logic [10:0] bits, input int n);
    #1;
    for (int i = 0; i < n; i++) begin
      dat_pull[ch] = ~bits[i];
      #40 clk_pull[ch] = 1'b1;
      #80 clk_pull[ch] = 1'b0;
      #40;
    end
    dat_pull[ch] = 1'b0;
  endtask

  // engine to peripheral: collects what follows falls 1 to 10
  task automatic take(input int ch, output logic [9:0] got);
    int n;
    n = 0;
    #1;
    while (!(clk_line[ch] === 1'b1 && dat_line[ch] === 1'b0) && n < 1000) begin
      #4 n++;
    end
    for (int k = 1; k <= 11; k++) begin
      #40 clk_pull[ch] = 1'b1;
      #80 clk_pull[ch] = 1'b0;
      #40;
      if (k <= 10) begin
        got[k-1] = dat_line[ch];
      end
      if (k == 10) begin
        dat_pull[ch] = 1'b1;
      end
    end
    dat_pull[ch] = 1'b0;
  endtask
endmodule

// ---- sim/tb_kmls_shifter.sv ----
`timescale 1ns/10ps
module tb_kmls_shifter;
  import kmls_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] clk_oe, dat_oe, clk_pull, dat_pull;
  wire [3:0] clk_line = ~clk_oe & ~clk_pull;
  wire [3:0] dat_line = ~dat_oe & ~dat_pull;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 43;
  logic [7:0] exp_q [$];
  int ach_tab [4] = '{1, 2, 4, 5};
  int dpos [4] = '{0, 1, 2, 6};
  int cpos [4] = '{3, 4, 5, 7};

  always #2 aclk = ~aclk;

  kmls_shifter kmls_shifter_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .clk_line_in(clk_line), .clk_line_out(), .clk_line_oe(clk_oe),
    .dat_line_in(dat_line), .dat_line_out(), .dat_line_oe(dat_oe), .irq(irq)
  );

  kmls_periph kmls_periph_i (
    .clk_line(clk_line), .dat_line(dat_line), .clk_pull(clk_pull), .dat_pull(dat_pull)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic close_out;
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // write, then let the pins settle
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk("write response", {1'b1, RESP_OKAY}, {bvalid, bresp});
    repeat (3) @(posedge aclk);
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    d = rdata;
    r = (rvalid === 1'b1) ? rresp : 2'bxx;
  endtask

  task automatic rchk(input string what, input logic [15:0] idx, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(what, {24'h0, e}, d);
    chk("read response", RESP_OKAY, r);
  endtask

  initial begin
    #200000;
    num_errors++;
    close_out();
  end

  initial begin
    logic [7:0] b;
    logic [9:0] got;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] sel;
    int ch;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("control", IDX_CTRL, CTRL_RST);
    rchk("line drive", IDX_DRIVE, 8'h47);
    rchk("irq mask", IDX_MASK, MASK_RST);
    rchk("status", IDX_STAT, 8'h00);
    rd(16'hFE8C, d, r);
    chk("unmapped resp", RESP_DECERR, r);
    chk("unmapped data", 0, d);
    // one transmit per channel, every mask setting
    for (int c = 0; c < 4; c++) begin
      b = $random(seed);
      exp_q.push_back(b);
      sel = 4'h1 << c;
      wr(IDX_CTRL, 8'h03);
      chk("tx inactive lines", 8'hF0, {clk_oe, dat_oe});
      wr(IDX_MASK, c[7:0]);
      wr(IDX_DATA, b);
      wr(IDX_DRIVE, 8'h47 & ~(8'h1 << dpos[c]));
      chk("data pulled", {28'h0, sel}, dat_oe);
      wr(IDX_DRIVE, (8'h47 & ~(8'h1 << dpos[c])) | (8'h1 << cpos[c]));
      chk("tx idle lines", {24'h0, ~sel, sel}, {clk_oe, dat_oe});
      kmls_periph_i.take(c, got);
      chk("tx byte", exp_q.pop_front(), got[7:0]);
      chk("tx parity", ~^b, got[8]);
      chk("tx stop", 1, got[9]);
      repeat (40) @(posedge aclk);
      chk("tx end lines", 8'hF0, {clk_oe, dat_oe});
      rchk("tx status", IDX_STAT, {2'b00, ach_tab[c][2:0], 3'b011});
      chk("tx irq", |c[1:0], irq);
      wr(IDX_DRIVE, 8'h47);
      rchk("status cleared", IDX_STAT, 8'h00);
      wr(IDX_CTRL, 8'h00);
    end
    // receive: good frame, bad parity, stop bit low
    for (int i = 0; i < 3; i++) begin
      ch = $unsigned($random(seed)) % 4;
      b = $random(seed);
      exp_q.push_back(b);
      wr(IDX_CTRL, {1'b0, i[2:0], 4'h1});
      wr(IDX_MASK, 8'h02);
      wr(IDX_DRIVE, 8'h47 | (8'h1 << cpos[ch]));
      kmls_periph_i.send(ch, {i != 2, (~^b) ^ (i == 1), b, 1'b0}, 11);
      repeat (20) @(posedge aclk);
      chk("rx end clocks", 4'hF, clk_oe);
      for (int k = 0; k < 2; k++) begin
        rchk("rx status", IDX_STAT, {1'b0, i == 2, ach_tab[ch][2:0], i == 1, 2'b11});
      end
      rchk("rx byte", IDX_DATA, exp_q.pop_front());
      chk("rx irq", 1, irq);
      wr(IDX_DRIVE, 8'h47);
      wr(IDX_CTRL, 8'h00);
    end
    // abort in mid receive
    wr(IDX_CTRL, 8'h01);
    wr(IDX_MASK, 8'h03);
    wr(IDX_DRIVE, 8'h4F);
    kmls_periph_i.send(0, 11'h0AA, 4);
    repeat (10) @(posedge aclk);
    rchk("mid status", IDX_STAT, 8'h09);
    chk("mid irq", 1, irq);
    wr(IDX_DRIVE, 8'h47);
    rchk("abort status", IDX_STAT, 8'h00);
    chk("abort lines", 8'hF0, {clk_oe, dat_oe});
    rchk("line sense", IDX_SENSE, 8'hF0);
    chk("abort irq", 0, irq);
    close_out();
  end
endmodule
